/* rtl/sfcs_pkg.sv */
// Constants shared by the serial unit and its receiver.
// Assumes a 32-bit AXI4-Lite bus decoded on the low address byte.
package sfcs_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_CTL    = 8'h04;
  localparam logic [7:0] ADDR_DIV    = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // serial_format_reg fields
  localparam int FMT_SYNC  = 7;
  localparam int FMT_CHR7  = 6;
  localparam int FMT_PAR   = 5;
  localparam int FMT_ODD   = 4;
  localparam int FMT_STOP2 = 3;
  localparam int FMT_MP    = 2;
  // serial_ctl_reg fields
  localparam int CTL_TXEN  = 5;
  localparam int CTL_RXEN  = 4;
  localparam int CTL_CKHI  = 1;
  localparam int CTL_CKLO  = 0;
  // Status fields
  localparam int ST_TXEMPTY = 7;
  localparam int ST_RXFULL  = 6;
  localparam int ST_OVR     = 5;
  localparam int ST_FRM     = 4;
  localparam int ST_PAR     = 3;
  localparam int ST_TXEND   = 2;
  localparam int ST_MPB     = 1;
  // Transmit data multiprocessor bit
  localparam int TXD_MPB    = 8;
  // Reset values
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  // Bit timing in ticks of the 16x clock
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK   = 4'hF;
  localparam logic [2:0] LAST_BIT8   = 3'h7;
  localparam logic [2:0] LAST_BIT7   = 3'h6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Frame position of a transmitter or receiver
  typedef enum logic [2:0] {
    B_IDLE  = 3'b000,
    B_START = 3'b001,
    B_DATA  = 3'b010,
    B_EXTRA = 3'b011,
    B_STOP  = 3'b100,
    B_STOP2 = 3'b101
  } sfcs_bit_e;
endpackage

/* rtl/sfcs_rx.sv */
// Receive shifter of the serial unit, both modes.
// Assumes tick16 and syncSample are one-cycle enables on core_clk.
`timescale 1ns/10ps
module sfcs_rx (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Mode and format
  input  wire logic       enable,
  input  wire logic       syncMode,
  input  wire logic       chr7,
  input  wire logic       parEn,
  input  wire logic       oddPar,
  input  wire logic       stop2,
  input  wire logic       mpFmt,
  // Timing and line
  input  wire logic       tick16,
  input  wire logic       syncSample,
  input  wire logic       rxd,
  // Received character
  output logic            done,
  output logic [7:0]      data,
  output logic            mpBit,
  output logic            parErr,
  output logic            frmErr
);
  typedef struct packed {
    sfcs_pkg::sfcs_bit_e state;
    logic [3:0]          cnt;
    logic [2:0]          idx;
    logic [7:0]          shift;
    logic                extra;
    logic                lastRxd;
    logic                done;
    logic [7:0]          data;
    logic                mpBit;
    logic                parErr;
    logic                frmErr;
  } sfcs_rx_s;

  sfcs_rx_s s;
  sfcs_rx_s next_s;

  always_comb begin
    logic [7:0] word;
    word = chr7 ? {1'b0, s.shift[7:1]} : s.shift;
    next_s = s;
    next_s.done = 1'b0;
    next_s.lastRxd = rxd;
    if (!enable) begin
      next_s.state = sfcs_pkg::B_IDLE;
    end else if (syncMode) begin
      if (s.state != sfcs_pkg::B_DATA) begin
        next_s.state = sfcs_pkg::B_DATA;
        next_s.idx = 3'h0;
      end else if (syncSample) begin
        next_s.shift = {rxd, s.shift[7:1]};
        next_s.idx = s.idx + 3'h1;
        if (s.idx == sfcs_pkg::LAST_BIT8) begin // [R1]
          next_s.done = 1'b1;
          next_s.data = {rxd, s.shift[7:1]};
          next_s.mpBit = 1'b0;
          next_s.parErr = 1'b0; // [R2]
          next_s.frmErr = 1'b0; // [R2]
        end
      end
    end else if (s.state == sfcs_pkg::B_IDLE) begin
      if (s.lastRxd && !rxd) begin // [R15] [R17]
        next_s.state = sfcs_pkg::B_START;
        next_s.cnt = 4'h0;
      end
    end else if (tick16) begin
      next_s.cnt = s.cnt + 4'h1;
      if (s.cnt == sfcs_pkg::SAMPLE_TICK) begin // [R18]
        unique case (s.state)
          sfcs_pkg::B_START: begin
            if (rxd) begin
              next_s.state = sfcs_pkg::B_IDLE; // [R21]
            end else begin
              next_s.state = sfcs_pkg::B_DATA;
              next_s.idx = 3'h0;
            end
          end
          sfcs_pkg::B_DATA: begin
            next_s.shift = {rxd, s.shift[7:1]}; // [R16]
            next_s.idx = s.idx + 3'h1;
            if (s.idx == (chr7 ? sfcs_pkg::LAST_BIT7 : sfcs_pkg::LAST_BIT8)) begin // [R4]
              next_s.state = (parEn || mpFmt) ? sfcs_pkg::B_EXTRA : sfcs_pkg::B_STOP;
            end
          end
          sfcs_pkg::B_EXTRA: begin
            next_s.extra = rxd;
            next_s.state = sfcs_pkg::B_STOP;
          end
          sfcs_pkg::B_STOP: begin
            next_s.done = 1'b1;
            next_s.data = word;
            next_s.frmErr = !rxd;
            next_s.mpBit = mpFmt && s.extra; // [R7]
            next_s.parErr = parEn && !mpFmt && ((^word ^ s.extra) != oddPar); // [R5] [R19]
            next_s.state = stop2 ? sfcs_pkg::B_STOP2 : sfcs_pkg::B_IDLE; // [R6]
          end
          sfcs_pkg::B_STOP2: begin
            next_s.state = sfcs_pkg::B_IDLE; // [R20]
          end
          default: begin
            next_s.state = sfcs_pkg::B_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{state: sfcs_pkg::B_IDLE, lastRxd: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign data = s.data;
  assign mpBit = s.mpBit;
  assign parErr = s.parErr;
  assign frmErr = s.frmErr;
endmodule // sfcs_rx

/* rtl/sfcs_top.sv */
// Serial unit: AXI4-Lite registers, clock select, transmitter, receive buffer.
// Assumes rxd and sckIn are synchronous to core_clk; sck pad resolved outside.
// Function
// (R1) Synchronous mode frames are always eight data bits, no extra or stop bits.
// (R2) Synchronous receive reports only overrun, never framing or parity errors.
// (R3) Format bit 7 selects asynchronous (0) or synchronous (1) operation.
// (R4) Format bit 6 selects eight (0) or seven (1) data bits.
// (R5) Format bit 5 adds one parity bit after the data.
// (R6) Format bit 3 selects one or two stop bits.
// (R7) Format bit 2 sends a multiprocessor bit instead of parity.
// (R8) Async, clock select 00: internal generator, clock pin unused.
// (R9) Async, clock select 01: internal generator, bit-rate clock driven out.
// (R10) Async, upper select set: clock pin supplies sixteen times bit rate.
// (R11) Sync, upper select clear: internal clock driven out on clock pin.
// (R12) Sync, upper select set: shift on clock from far end.
// (R13) Transmit and receive paths run independently for full duplex.
// (R14) Transmit and receive each hold one buffered character beyond the shifter.
// (R15) Async line idles high; a low start bit begins each character.
// (R16) Order: start, data LSB first, parity or multiprocessor bit, stops.
// (R17) Receiver aligns bit timing to the start bit falling edge.
// (R18) Receiver samples on the eighth tick of the 16x clock.
// (R19) Parity matches the even or odd polarity bit.
// (R20) After the stop bits the receiver waits for the next falling edge.
// (R21) A start bit found high at mid-bit is dropped as noise.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module sfcs_top #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial pins
  output logic             txd,
  input  wire logic        rxd,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOeN
);
  if (DIV_W < 4 || DIV_W > 16) begin : g_check
    $error("DIV_W must lie between 4 and 16");
  end

  typedef struct packed {
    logic [7:0]          fmt;
    logic [7:0]          ctl;
    logic [DIV_W-1:0]    div;
    logic [DIV_W-1:0]    divCnt;
    logic                sckPrev;
    logic                sckInt;
    logic                sckDrv;
    logic                sckOeN;
    sfcs_pkg::sfcs_bit_e txState;
    logic [3:0]          txPhase;
    logic [2:0]          txIdx;
    logic [7:0]          txShift;
    logic                txExtra;
    logic                txLine;
    logic [7:0]          txBuf;
    logic                txBufMpb;
    logic                txBufFull;
    logic                txEnd;
    logic [7:0]          rxData;
    logic                rxMpb;
    logic                rxFull;
    logic                ovr;
    logic                frm;
    logic                perr;
    logic                awHeld;
    logic [7:0]          awAddr;
    logic                wHeld;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } sfcs_top_s;

  sfcs_top_s s;
  sfcs_top_s next_s;

  logic       syncMode;
  logic       ckHi;
  logic       ckLo;
  logic       rxEnable;
  logic       tick16;
  logic       syncRise;
  logic       syncFall;
  logic       rxDone;
  logic [7:0] rxWord;
  logic       rxMpBit;
  logic       rxParErr;
  logic       rxFrmErr;

  assign syncMode = s.fmt[sfcs_pkg::FMT_SYNC]; // [R3]
  assign ckHi = s.ctl[sfcs_pkg::CTL_CKHI];
  assign ckLo = s.ctl[sfcs_pkg::CTL_CKLO];
  // Receiving stops while an error flag stands
  assign rxEnable = s.ctl[sfcs_pkg::CTL_RXEN] && !s.ovr && !s.frm && !s.perr;

  // Receiver runs on its own timing, apart from the transmitter
  sfcs_rx u_rx ( // [R13]
    .core_clk   (core_clk),
    .resetn     (resetn),
    .enable     (rxEnable),
    .syncMode   (syncMode),
    .chr7       (s.fmt[sfcs_pkg::FMT_CHR7]),
    .parEn      (s.fmt[sfcs_pkg::FMT_PAR]),
    .oddPar     (s.fmt[sfcs_pkg::FMT_ODD]),
    .stop2      (s.fmt[sfcs_pkg::FMT_STOP2]),
    .mpFmt      (s.fmt[sfcs_pkg::FMT_MP]),
    .tick16     (tick16),
    .syncSample (syncRise),
    .rxd        (rxd),
    .done       (rxDone),
    .data       (rxWord),
    .mpBit      (rxMpBit),
    .parErr     (rxParErr),
    .frmErr     (rxFrmErr)
  );

  always_comb begin
    logic       divTick;
    logic       sckRise;
    logic       sckFall;
    logic       syncRun;
    logic       txDone;
    logic       load;
    logic       chr7;
    logic       mpFmt;
    logic [7:0] masked;
    logic [31:0] rd;
    logic       rdOk;
    divTick = 1'b0;
    sckRise = 1'b0;
    sckFall = 1'b0;
    syncRun = 1'b0;
    txDone = 1'b0;
    load = 1'b0;
    chr7 = s.fmt[sfcs_pkg::FMT_CHR7] && !syncMode;
    mpFmt = s.fmt[sfcs_pkg::FMT_MP] && !syncMode;
    masked = chr7 ? {1'b0, s.txBuf[6:0]} : s.txBuf;
    rd = 32'h0000_0000;
    rdOk = 1'b1;
    next_s = s;
    tick16 = 1'b0;
    syncRise = 1'b0;
    syncFall = 1'b0;

    // Bit rate generator and clock pin
    divTick = (s.divCnt == '0);
    next_s.divCnt = divTick ? s.div : s.divCnt - 1'b1;
    next_s.sckPrev = sckIn;
    sckRise = !s.sckPrev && sckIn;
    sckFall = s.sckPrev && !sckIn;
    syncRun = (s.txState == sfcs_pkg::B_DATA) || (rxEnable && !s.rxFull);
    tick16 = !syncMode && (ckHi ? sckRise : divTick); // [R8] [R10]
    if (ckHi) begin
      syncRise = syncMode && sckRise; // [R12]
      syncFall = syncMode && sckFall; // [R12]
    end else begin
      syncRise = syncMode && divTick && !s.sckInt; // [R11]
      syncFall = syncMode && divTick && s.sckInt && syncRun; // [R11]
    end
    if (syncRise) begin
      next_s.sckInt = 1'b1;
    end else if (syncFall) begin
      next_s.sckInt = 1'b0;
    end
    if (syncMode) begin
      next_s.sckDrv = s.sckInt;
      next_s.sckOeN = ckHi; // [R11] [R12]
    end else begin
      // Rising edge at the centre of each transmitted bit
      next_s.sckDrv = s.txPhase[3] || (s.txState == sfcs_pkg::B_IDLE); // [R9]
      next_s.sckOeN = ckHi || !ckLo; // [R8] [R9] [R10]
    end

    // Transmitter
    if (!s.ctl[sfcs_pkg::CTL_TXEN]) begin
      next_s.txState = sfcs_pkg::B_IDLE;
      next_s.txBufFull = 1'b0;
      next_s.txEnd = 1'b1;
      next_s.txLine = 1'b1;
    end else if (syncMode) begin
      if (s.txState != sfcs_pkg::B_DATA) begin
        next_s.txState = sfcs_pkg::B_IDLE;
        load = s.txBufFull;
      end else if (syncRise) begin
        next_s.txIdx = s.txIdx + 3'h1;
        if (s.txIdx == sfcs_pkg::LAST_BIT8) begin // [R1]
          next_s.txState = sfcs_pkg::B_IDLE;
          next_s.txEnd = !s.txBufFull;
        end
      end else if (syncFall) begin
        next_s.txShift = {1'b0, s.txShift[7:1]};
        next_s.txLine = s.txShift[1];
      end
    end else if (s.txState == sfcs_pkg::B_IDLE) begin
      next_s.txLine = 1'b1; // [R15]
      load = s.txBufFull;
    end else if (tick16) begin
      next_s.txPhase = s.txPhase + 4'h1;
      if (s.txPhase == sfcs_pkg::LAST_TICK) begin
        unique case (s.txState)
          sfcs_pkg::B_START: begin
            next_s.txState = sfcs_pkg::B_DATA;
            next_s.txLine = s.txShift[0]; // [R16]
          end
          sfcs_pkg::B_DATA: begin
            next_s.txIdx = s.txIdx + 3'h1;
            next_s.txShift = {1'b0, s.txShift[7:1]};
            next_s.txLine = s.txShift[1];
            if (s.txIdx == (chr7 ? sfcs_pkg::LAST_BIT7 : sfcs_pkg::LAST_BIT8)) begin // [R4]
              if (s.fmt[sfcs_pkg::FMT_PAR] || mpFmt) begin
                next_s.txState = sfcs_pkg::B_EXTRA; // [R5] [R7]
                next_s.txLine = s.txExtra;
              end else begin
                next_s.txState = sfcs_pkg::B_STOP;
                next_s.txLine = 1'b1;
              end
            end
          end
          sfcs_pkg::B_EXTRA: begin
            next_s.txState = sfcs_pkg::B_STOP;
            next_s.txLine = 1'b1; // [R16]
          end
          sfcs_pkg::B_STOP: begin
            if (s.fmt[sfcs_pkg::FMT_STOP2]) begin // [R6]
              next_s.txState = sfcs_pkg::B_STOP2;
            end else begin
              txDone = 1'b1;
            end
          end
          sfcs_pkg::B_STOP2: begin
            txDone = 1'b1;
          end
          default: begin
            next_s.txState = sfcs_pkg::B_IDLE;
          end
        endcase
      end
    end
    if (txDone) begin
      next_s.txState = sfcs_pkg::B_IDLE;
      next_s.txEnd = !s.txBufFull;
      load = s.txBufFull;
    end
    // Next character leaves the buffer as the frame starts
    if (load) begin // [R14]
      next_s.txShift = s.txBuf;
      next_s.txBufFull = 1'b0;
      next_s.txEnd = 1'b0;
      next_s.txIdx = 3'h0;
      next_s.txPhase = 4'h0;
      next_s.txExtra = mpFmt ? s.txBufMpb : (^masked ^ s.fmt[sfcs_pkg::FMT_ODD]); // [R19]
      if (syncMode) begin
        next_s.txState = sfcs_pkg::B_DATA;
        next_s.txLine = s.txBuf[0];
      end else begin
        next_s.txState = sfcs_pkg::B_START;
        next_s.txLine = 1'b0; // [R15] [R16]
      end
    end

    // Bus write
    if (s.awHeld && s.wHeld) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = sfcs_pkg::RESP_OKAY;
      unique case (s.awAddr)
        sfcs_pkg::ADDR_FORMAT: begin
          if (s.wStrb[0]) next_s.fmt = s.wData[7:0];
        end
        sfcs_pkg::ADDR_CTL: begin
          if (s.wStrb[0]) next_s.ctl = s.wData[7:0];
        end
        sfcs_pkg::ADDR_DIV: begin
          for (int b = 0; b < DIV_W; b++) begin
            if (s.wStrb[b / 8]) next_s.div[b] = s.wData[b];
          end
        end
        sfcs_pkg::ADDR_TXDATA: begin
          if (s.wStrb[0]) begin // [R14]
            next_s.txBuf = s.wData[7:0];
            next_s.txBufMpb = s.wData[sfcs_pkg::TXD_MPB];
            next_s.txBufFull = s.ctl[sfcs_pkg::CTL_TXEN];
          end
        end
        sfcs_pkg::ADDR_STATUS: begin
          if (s.wStrb[0]) begin
            next_s.ovr = s.ovr && !s.wData[sfcs_pkg::ST_OVR];
            next_s.frm = s.frm && !s.wData[sfcs_pkg::ST_FRM];
            next_s.perr = s.perr && !s.wData[sfcs_pkg::ST_PAR];
          end
        end
        sfcs_pkg::ADDR_RXDATA: begin
        end
        default: begin
          next_s.bresp = sfcs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = s_axi_wdata;
      next_s.wStrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Bus read
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      unique case (s_axi_araddr[7:0])
        sfcs_pkg::ADDR_FORMAT: rd[7:0] = s.fmt;
        sfcs_pkg::ADDR_CTL: rd[7:0] = s.ctl;
        sfcs_pkg::ADDR_DIV: rd[DIV_W-1:0] = s.div;
        sfcs_pkg::ADDR_TXDATA: rd[sfcs_pkg::TXD_MPB:0] = {s.txBufMpb, s.txBuf};
        sfcs_pkg::ADDR_RXDATA: begin
          rd[7:0] = s.rxData;
          next_s.rxFull = 1'b0; // [R14]
        end
        sfcs_pkg::ADDR_STATUS: begin
          rd[sfcs_pkg::ST_TXEMPTY] = !s.txBufFull;
          rd[sfcs_pkg::ST_RXFULL] = s.rxFull;
          rd[sfcs_pkg::ST_OVR] = s.ovr;
          rd[sfcs_pkg::ST_FRM] = s.frm;
          rd[sfcs_pkg::ST_PAR] = s.perr;
          rd[sfcs_pkg::ST_TXEND] = s.txEnd;
          rd[sfcs_pkg::ST_MPB] = s.rxMpb;
        end
        default: rdOk = 1'b0;
      endcase
      next_s.rvalid = 1'b1;
      next_s.rdata = rd;
      next_s.rresp = rdOk ? sfcs_pkg::RESP_OKAY : sfcs_pkg::RESP_SLVERR;
    end

    // Receive buffer; hardware sets win over software clears
    if (rxDone) begin
      if (s.rxFull) begin
        next_s.ovr = 1'b1; // [R2]
        next_s.rxFull = 1'b1;
      end else begin
        next_s.rxData = rxWord; // [R14]
        next_s.rxMpb = rxMpBit;
        next_s.rxFull = 1'b1;
        next_s.frm = next_s.frm || rxFrmErr;
        next_s.perr = next_s.perr || rxParErr;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{fmt: sfcs_pkg::FMT_RST, ctl: sfcs_pkg::CTL_RST, txState: sfcs_pkg::B_IDLE,
             sckPrev: 1'b1, sckInt: 1'b1, sckDrv: 1'b1, sckOeN: 1'b1, txLine: 1'b1,
             txEnd: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = !s.awHeld && !s.bvalid;
  assign s_axi_wready = !s.wHeld && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign txd = s.txLine;
  assign sckOut = s.sckDrv;
  assign sckOeN = s.sckOeN;
endmodule // sfcs_top

/* test/sfcs_top_asserts.sv */
// Port-level checker for sfcs_top, bound into every instance.
// Assumes a single core_clk domain with active-low resetn.
`timescale 1ns/10ps
module sfcs_top_asserts (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Serial line
  input wire logic        txd
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_awblk: assert property (p_awblk) else $error("write taken during response");
  property p_brise; $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready); endproperty
  a_brise: assert property (p_brise) else $error("write response without both halves");
  property p_bresp; s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}; endproperty
  a_bresp: assert property (p_bresp) else $error("illegal write response code");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready && s_axi_rresp inside {2'h0, 2'h2}; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken during answer");
  property p_txlow; $fell(txd) |-> !txd [*8]; endproperty
  a_txlow: assert property (p_txlow) else $error("start bit too short");
endmodule // sfcs_top_asserts
bind sfcs_top sfcs_top_asserts chk_u (.*);

/* test/sfcs_far_end.sv */
// Far-end async serial device: drives rxd, samples txd mid-bit.
// Assumes BIT core_clk cycles per serial bit.
`timescale 1ns/10ps
module sfcs_far_end #(
  parameter int BIT = 64
) (
  // Clock
  input  wire logic   core_clk,
  // Lines
  input  wire logic   txd,
  output logic        rxd,
  // Captured frame
  output logic [10:0] rxBits,
  output logic [7:0]  rxCnt
);
  initial begin
    rxd = 1'b1;
    rxCnt = 8'h00;
    rxBits = '1;
  end
  // Frame bits LSB first, marking after
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge core_clk);
    end
  endtask
  // Low pulse too short to be a start bit
  task automatic glitch();
    @(posedge core_clk);
    rxd <= 1'b0;
    repeat (BIT / 4) @(posedge core_clk);
    rxd <= 1'b1;
  endtask
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge core_clk);
    for (int k = 0; k < 11; k++) begin
      rxBits[k] = txd;
      repeat (BIT) @(posedge core_clk);
    end
    rxCnt = rxCnt + 8'h01;
  end
endmodule // sfcs_far_end

/* test/sfcs_top_tb.sv */
// Self-checking bench for sfcs_top: registers, async formats, clock pin.
// Assumes DIV=3, so one serial bit is 64 core_clk cycles.
`timescale 1ns/10ps
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, a, e); end \
end
module sfcs_top_tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, sckIn;
  logic [1:0]  sckPh = '0;
  logic [7:0]  nSck = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        txd, rxd, sckOut, sckOeN;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [10:0] rxBits;
  logic [7:0]  rxCnt;
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  // Free-running pin clock: one rise every 4 cycles, same tick rate as DIV=3
  always @(posedge core_clk) sckPh <= sckPh + 2'h1;
  assign sckIn = sckPh[1];
  always @(posedge sckOut) nSck <= nSck + 8'h01;
  sfcs_top dut_u (.*);
  sfcs_far_end #(.BIT(64)) far_u (.*);
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Expected line bits of one async character, idle ones after
  function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d, input logic m);
    logic [11:0] b;
    logic [7:0]  k;
    int          n;
    n = f[6] ? 7 : 8;
    k = f[6] ? {1'b0, d[6:0]} : d;
    b = '1;
    b[0] = 1'b0;
    for (int i = 0; i < n; i++) b[i + 1] = k[i];
    if (f[2]) b[n + 1] = m;
    else if (f[5]) b[n + 1] = ^k ^ f[4];
    return b;
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    logic [31:0] d, s;
    logic [1:0]  r;
    logic [7:0]  f, c, m, k;
    logic [11:0] e;
    static logic [7:0] fmts[8] = '{8'h00, 8'h08, 8'h20, 8'h38, 8'h40, 8'h70, 8'h24, 8'h4C};
    void'($urandom(16051));
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    `CHK(txd, 1'b1)
    rd(sfcs_pkg::ADDR_FORMAT, d, r);
    `CHK(d, 32'h0)
    rd(8'h20, d, r);
    `CHK(r, sfcs_pkg::RESP_SLVERR)
    wr(8'h20, 32'h0, r);
    `CHK(r, sfcs_pkg::RESP_SLVERR)
    wr(sfcs_pkg::ADDR_DIV, 32'h3, r);
    wr(sfcs_pkg::ADDR_CTL, 32'h10, r);
    far_u.glitch();
    repeat (768) @(posedge core_clk);
    rd(sfcs_pkg::ADDR_STATUS, s, r);
    `CHK(s[6], 1'b0)
    foreach (fmts[i]) begin
      f = fmts[i];
      c = {6'h0C, i[1:0]};
      wr(sfcs_pkg::ADDR_CTL, 32'h0, r);
      wr(sfcs_pkg::ADDR_FORMAT, {24'h0, f}, r);
      wr(sfcs_pkg::ADDR_CTL, {24'h0, c}, r);
      repeat (3) @(posedge core_clk);
      `CHK(sckOeN, c[1:0] != 2'b01)
      d = $urandom;
      m = 8'($urandom);
      e = frame(f, d[7:0], m[0]);
      k = rxCnt;
      fork
        wr(sfcs_pkg::ADDR_TXDATA, {23'h0, m[0], d[7:0]}, r);
        far_u.send(e);
      join
      for (int j = 0; j < 3000 && rxCnt == k; j++) @(posedge core_clk);
      `CHK(rxCnt != k, 1'b1)
      `CHK(rxBits, e[10:0])
      rd(sfcs_pkg::ADDR_STATUS, s, r);
      `CHK(s[7:3], 5'b11000)
      if (f[2]) `CHK(s[1], m[0])
      rd(sfcs_pkg::ADDR_RXDATA, s, r);
      `CHK(s[7:0], e[8:1] & {~f[6], 7'h7F})
    end
    wr(sfcs_pkg::ADDR_CTL, 32'h0, r);
    wr(sfcs_pkg::ADDR_FORMAT, 32'hE4, r);
    k = nSck;
    wr(sfcs_pkg::ADDR_CTL, 32'h31, r);
    repeat (3) @(posedge core_clk);
    `CHK(sckOeN, 1'b0)
    repeat (200) @(posedge core_clk);
    `CHK(nSck - k, 8'h08)
    rd(sfcs_pkg::ADDR_STATUS, s, r);
    `CHK(s[6:3], 4'b1000)
    rd(sfcs_pkg::ADDR_RXDATA, s, r);
    `CHK(s[7:0], 8'hFF)
    wr(sfcs_pkg::ADDR_CTL, 32'h32, r);
    repeat (3) @(posedge core_clk);
    `CHK(sckOeN, 1'b1)
    repeat (200) @(posedge core_clk);
    rd(sfcs_pkg::ADDR_STATUS, s, r);
    `CHK(s[6:3], 4'b1100)
    results();
  end
endmodule // sfcs_top_tb
